// ===== rtl/dwp_pkg.sv
// Package: command codes, timing counts and state encodings of the write/precharge controller
// Contract
// - Each strobe clocks its own byte lane.
// - Each mask gates its own byte lane.
// - WRITE without auto precharge leaves row open.
// - Measure recovery delays from rising edge after last pair.
// - Write-to-read delay only within one device.
// - Write recovery only within one device.
// - Keep strobe toggling through masked truncated slots.
// - Burst of four needs no later slots.
// - Auto precharge bit high selects all banks.
// - ACTIVE before READ or WRITE to idle bank.
// - Clock runs during write recovery.
// - No command to precharging bank before precharge time. The code still issues PRECHARGE to a precharging bank.
// - Other banks usable without disturbing data transfer.
// - Access period allows only ACTIVE or PRECHARGE elsewhere.
// - Precharge period allows all commands elsewhere.
// - First strobe rise one clock after WRITE.
package dwp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CK_DIV  = 2;
  localparam int CNT_W   = 8;

  // Minimum times round up to whole clk cycles
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Count down toward zero and hold there
  function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
    return (v == '0) ? v : v - 1'b1;
  endfunction

  localparam int T_RP_NS    = 15;
  localparam int T_RAS_NS   = 40;
  localparam int T_RCD_NS   = 15;
  localparam int T_WR_NS    = 15;
  localparam int WTR_CK     = 2;
  localparam int CAS_LAT_CK = 3;
  localparam int RP_CYC     = ns2cyc(T_RP_NS);
  localparam int RAS_CYC    = ns2cyc(T_RAS_NS);
  localparam int RCD_CYC    = ns2cyc(T_RCD_NS);
  localparam int WR_CYC     = ns2cyc(T_WR_NS);
  localparam int WTR_CYC    = WTR_CK * CK_DIV;

  // Pin codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;

  localparam int AP_BIT      = 10;
  localparam int WR_OE_OFS   = 1;
  localparam int WR_DATA_OFS = 3;

  typedef enum logic [1:0] {
    OP_ACT = 2'h0,
    OP_RD  = 2'h1,
    OP_WR  = 2'h2,
    OP_PRE = 2'h3
  } dwp_op_e;

  typedef enum logic [3:0] {
    BK_IDLE  = 4'h1,
    BK_OPEN  = 4'h2,
    BK_APW   = 4'h4,
    BK_PRECH = 4'h8
  } dwp_bank_e;
endpackage

// ===== rtl/dwp_bank.sv
// Per-bank state and timing tracker of the controller
module dwp_bank
  import dwp_pkg::*;
#(
  parameter int RCD_C  = RCD_CYC,
  parameter int RAS_C  = RAS_CYC,
  parameter int RP_C   = RP_CYC,
  parameter int WR_C   = WR_CYC,
  parameter int RDAP_C = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic act,
  input  wire logic rd,
  input  wire logic wr,
  input  wire logic pre,
  input  wire logic ap,
  input  wire logic wr_done,
  output logic      is_open,
  output logic      can_act,
  output logic      can_access,
  output logic      can_pre,
  output logic      in_ap
);
  dwp_bank_e        st_q, st_d;
  logic [CNT_W-1:0] ras_q, rcd_q, rp_q, wr_q, rdap_q;
  logic             wr_pend_q;
  wire logic        pre_eff;
  wire logic        ap_start;

  // A closed or closing bank ignores PRECHARGE
  assign pre_eff  = pre & (st_q == BK_OPEN);
  // Internal precharge waits for row time, read data and recovery
  assign ap_start = (st_q == BK_APW) & (ras_q == '0) & (rdap_q == '0)
                  & ~wr_pend_q & (wr_q == '0);

  // Bank state sequence
  always_comb begin
    st_d = st_q;
    case (st_q)
      BK_IDLE:  if (act && rp_q == '0) st_d = BK_OPEN;
      BK_OPEN: begin
        if ((rd || wr) && ap) st_d = BK_APW;
        else if (pre_eff) st_d = BK_PRECH;
      end
      BK_APW:   if (ap_start) st_d = BK_PRECH;
      BK_PRECH: if (rp_q == '0) st_d = BK_IDLE;
      default:  st_d = BK_IDLE;
    endcase
  end

  // State and timers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q      <= BK_IDLE;
      ras_q     <= '0;
      rcd_q     <= '0;
      rp_q      <= '0;
      wr_q      <= '0;
      rdap_q    <= '0;
      wr_pend_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      ras_q     <= act ? CNT_W'(RAS_C) : dec(ras_q);
      rcd_q     <= act ? CNT_W'(RCD_C) : dec(rcd_q);
      rp_q      <= (pre_eff || ap_start) ? CNT_W'(RP_C) : dec(rp_q);
      wr_q      <= (wr_done && wr_pend_q) ? CNT_W'(WR_C) : dec(wr_q);
      rdap_q    <= (rd && ap) ? CNT_W'(RDAP_C) : dec(rdap_q);
      wr_pend_q <= wr | (wr_pend_q & ~wr_done);
    end
  end

  assign is_open    = (st_q == BK_OPEN);
  assign in_ap      = (st_q == BK_APW);
  assign can_act    = (st_q == BK_IDLE) & (rp_q == '0);
  assign can_access = is_open & (rcd_q == '0);
  assign can_pre    = is_open & (ras_q == '0) & ~wr_pend_q & (wr_q == '0);
endmodule

// ===== rtl/dwp_ctrl.sv
// Host controller: issues ACTIVE, READ, WRITE and PRECHARGE and drives write data
module dwp_ctrl
  import dwp_pkg::*;
#(
  parameter int DQ_W      = 16,
  parameter int BURST_LEN = 4,
  parameter int ADDR_W    = 13,
  parameter int RCD_C     = RCD_CYC,
  parameter int RAS_C     = RAS_CYC,
  parameter int RP_C      = RP_CYC,
  parameter int WR_C      = WR_CYC,
  parameter int WTR_C     = WTR_CYC,
  parameter int CL_CK     = CAS_LAT_CK
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        req_valid,
  input  wire logic [1:0]                  req_op,
  input  wire logic [1:0]                  req_bank,
  input  wire logic [ADDR_W-1:0]           req_row,
  input  wire logic [ADDR_W-1:0]           req_col,
  input  wire logic                        req_auto_pre,
  input  wire logic                        req_all,
  input  wire logic [BURST_LEN*DQ_W-1:0]   req_wdata,
  input  wire logic [BURST_LEN*DQ_W/8-1:0] req_wmask,
  input  wire logic [4:0]                  req_pairs,
  output logic                             req_accept,
  output logic [3:0]                       bank_open,
  output logic                             wr_busy,
  output logic                             mem_ck,
  output logic                             mem_ck_n,
  output logic                             mem_cke,
  output logic                             mem_cs_n,
  output logic                             mem_ras_n,
  output logic                             mem_cas_n,
  output logic                             mem_we_n,
  output logic [ADDR_W-1:0]                mem_addr,
  output logic [1:0]                       mem_ba,
  output logic [DQ_W-1:0]                  mem_dq_o,
  output logic                             mem_dq_oe,
  output logic [DQ_W/8-1:0]                mem_strobe_o,
  output logic                             mem_strobe_oe,
  output logic [DQ_W/8-1:0]                mem_mask
);
  localparam int LANES  = DQ_W / 8;
  localparam int RDAP_C = BURST_LEN / 2 * CK_DIV;
  localparam int RDWR_C = (CL_CK + BURST_LEN / 2 + 1) * CK_DIV;
  localparam int WR_END = BURST_LEN + WR_DATA_OFS;

  // ---------------------------------------------------------------
  // Clock divider and command slot
  // ---------------------------------------------------------------
  logic ph_q;
  logic ckn_q;
  logic cke_q;

  // Link clock is clk divided by two; commands change on its fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_q  <= 1'b0;
      ckn_q <= 1'b1;
      cke_q <= 1'b0;
    end else begin
      ph_q  <= ~ph_q;
      ckn_q <= ph_q;
      cke_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Bank trackers
  // ---------------------------------------------------------------
  logic [3:0] bk_open, bk_can_act, bk_can_acc, bk_can_pre, bk_in_ap;
  logic [3:0] bk_act, bk_rd, bk_wr, bk_pre;
  logic       wr_done_q;

  for (genvar i = 0; i < 4; i++) begin : g_bank
    dwp_bank #(
      .RCD_C  (RCD_C),
      .RAS_C  (RAS_C),
      .RP_C   (RP_C),
      .WR_C   (WR_C),
      .RDAP_C (RDAP_C)
    ) u_bank (
      .clk        (clk),
      .rst_n      (rst_n),
      .act        (bk_act[i]),
      .rd         (bk_rd[i]),
      .wr         (bk_wr[i]),
      .pre        (bk_pre[i]),
      .ap         (req_auto_pre),
      .wr_done    (wr_done_q),
      .is_open    (bk_open[i]),
      .can_act    (bk_can_act[i]),
      .can_access (bk_can_acc[i]),
      .can_pre    (bk_can_pre[i]),
      .in_ap      (bk_in_ap[i])
    );
  end

  // ---------------------------------------------------------------
  // Request legality
  // ---------------------------------------------------------------
  logic             wr_busy_q;
  logic [CNT_W-1:0] wtr_q;
  logic [CNT_W-1:0] rdgap_q;
  wire logic        any_ap;
  wire logic [3:0]  pre_okv;
  wire logic        ok_act, ok_rd, ok_wr, ok_pre;
  wire logic        legal;
  wire logic        take;
  wire logic [3:0]  bsel;
  wire logic [3:0]  pre_tgt;
  wire logic        op_act, op_rd, op_wr, op_pre;
  wire logic        rd_take;
  logic             legal_c;

  // Auto precharge access period blocks column commands anywhere
  assign any_ap  = |bk_in_ap;
  // Closed or precharging banks take PRECHARGE as a NOP
  assign pre_okv = bk_can_pre | ~(bk_open | bk_in_ap);
  assign bsel    = 4'h1 << req_bank;
  assign ok_act  = |(bk_can_act & bsel);
  assign ok_rd   = |(bk_can_acc & bsel) & ~any_ap & ~wr_busy_q
                 & (wtr_q == '0);
  assign ok_wr   = |(bk_can_acc & bsel) & ~any_ap & ~wr_busy_q
                 & (rdgap_q == '0);
  assign ok_pre  = req_all ? &pre_okv : |(pre_okv & bsel);

  // One strobe per kind of request
  assign op_act  = (req_op == OP_ACT);
  assign op_rd   = (req_op == OP_RD);
  assign op_wr   = (req_op == OP_WR);
  assign op_pre  = (req_op == OP_PRE);

  // Legality by operation
  always_comb begin
    case (dwp_op_e'(req_op))
      OP_ACT:  legal_c = ok_act;
      OP_RD:   legal_c = ok_rd;
      OP_WR:   legal_c = ok_wr;
      OP_PRE:  legal_c = ok_pre;
      default: legal_c = 1'b0;
    endcase
  end
  // Legality of the presented operation
  assign legal = legal_c;

  // Requests are taken only on the slot before a falling link edge
  assign take = req_valid & ph_q & legal;

  // Precharge all reaches every bank, else the addressed one
  assign pre_tgt = req_all ? 4'hf : bsel;

  // Per-bank command strobes
  assign bk_act  = (take && op_act) ? bsel : 4'h0;
  assign bk_rd   = (take && op_rd)  ? bsel : 4'h0;
  assign bk_wr   = (take && op_wr)  ? bsel : 4'h0;
  assign bk_pre  = (take && op_pre) ? pre_tgt : 4'h0;
  // Taken read starts the read-to-write gap
  assign rd_take = take & op_rd;

  // ---------------------------------------------------------------
  // Command and address pins
  // ---------------------------------------------------------------
  logic [3:0]        cmd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [1:0]        ba_q;
  wire logic [3:0]        cmd_d;
  wire logic [ADDR_W-1:0] addr_d;

  // Column address with the auto precharge select bit overlaid
  function automatic logic [ADDR_W-1:0] with_ap(input logic [ADDR_W-1:0] a,
                                                 input logic            b);
    logic [ADDR_W-1:0] r;
    r         = a;
    r[AP_BIT] = b;
    return r;
  endfunction

  // Command decode
  assign cmd_d  = !take                ? CMD_NOP :
                  (req_op == OP_ACT)   ? CMD_ACT :
                  (req_op == OP_RD)    ? CMD_RD  :
                  (req_op == OP_WR)    ? CMD_WR  : CMD_PRE;
  assign addr_d = (req_op == OP_ACT) ? req_row :
                  (req_op == OP_PRE) ? with_ap(req_row, req_all)
                                     : with_ap(req_col, req_auto_pre);

  // Command held for one full link clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q  <= CMD_NOP;
      addr_q <= '0;
      ba_q   <= 2'h0;
    end else if (ph_q) begin
      cmd_q  <= cmd_d;
      addr_q <= take ? addr_d : addr_q;
      ba_q   <= take ? req_bank : ba_q;
    end
  end

  // ---------------------------------------------------------------
  // Write data engine
  // ---------------------------------------------------------------
  logic [CNT_W-1:0]           wcnt_q;
  logic [BURST_LEN*DQ_W-1:0]  wdat_q;
  logic [BURST_LEN*LANES-1:0] wmsk_q;
  logic [4:0]                 pairs_q;
  logic [DQ_W-1:0]            dq_q;
  logic                       dq_oe_q;
  logic [LANES-1:0]           strb_q;
  logic                       strb_oe_q;
  logic [LANES-1:0]           dm_q;
  wire logic                  wr_take;
  wire logic [CNT_W-1:0]      wj;
  wire logic [CNT_W-1:0]      elem;
  wire logic                  in_oe;
  wire logic                  in_data;
  wire logic                  cut;
  wire logic                  wr_last;
  wire logic                  wr_stop;
  wire logic                  strb_hi;
  wire logic [LANES-1:0]      lane_mask;

  assign wr_take = take & op_wr;
  assign wj      = wcnt_q + 1'b1;
  assign elem    = wj - CNT_W'(WR_DATA_OFS);
  // Strobe driven from preamble to postamble only
  assign in_oe   = wr_busy_q & (wj >= CNT_W'(WR_OE_OFS)) & (wj <= CNT_W'(WR_END));
  // Data slots start one link clock after the command
  assign in_data = wr_busy_q & (wj >= CNT_W'(WR_DATA_OFS)) & (wj < CNT_W'(WR_END));
  // Slots beyond the wanted pairs are masked, strobe keeps running
  assign cut     = elem >= CNT_W'({pairs_q, 1'b0});

  // Postamble slot ends the data of the burst
  assign wr_last   = wr_busy_q & (wj == CNT_W'(WR_END));
  // Engine frees itself one slot after the postamble
  assign wr_stop   = wr_busy_q & (wj == CNT_W'(WR_END + 1));
  // Even elements ride the rising strobe edge
  assign strb_hi   = in_data & ~elem[0];
  // Own lane masks, all lanes once the wanted pairs are out
  assign lane_mask = wmsk_q[LANES-1:0] | {LANES{cut}};

  // Burst sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_busy_q <= 1'b0;
      wcnt_q    <= '0;
      wr_done_q <= 1'b0;
      pairs_q   <= 5'h0;
    end else begin
      wr_busy_q <= wr_take | (wr_busy_q & ~wr_stop);
      wcnt_q    <= wr_take ? '0 : (wr_busy_q ? wj : wcnt_q);
      wr_done_q <= wr_last;
      pairs_q   <= wr_take ? req_pairs : pairs_q;
    end
  end

  // Data and mask shift registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdat_q <= '0;
      wmsk_q <= '0;
    end else if (wr_take) begin
      wdat_q <= req_wdata;
      wmsk_q <= req_wmask;
    end else if (in_data) begin
      wdat_q <= wdat_q >> DQ_W;
      wmsk_q <= wmsk_q >> LANES;
    end
  end

  // Pin registers for data, strobes and masks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dq_q      <= '0;
      dq_oe_q   <= 1'b0;
      strb_q    <= '0;
      strb_oe_q <= 1'b0;
      dm_q      <= '0;
    end else begin
      dq_q      <= in_data ? wdat_q[DQ_W-1:0] : '0;
      dq_oe_q   <= in_data;
      strb_q    <= {LANES{strb_hi}};
      strb_oe_q <= in_oe;
      dm_q      <= in_data ? lane_mask : '0;
    end
  end

  // ---------------------------------------------------------------
  // Turnaround timers
  // ---------------------------------------------------------------
  // Write-to-read and read-to-write spacing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wtr_q   <= '0;
      rdgap_q <= '0;
    end else begin
      wtr_q   <= wr_done_q ? CNT_W'(WTR_C) : dec(wtr_q);
      rdgap_q <= rd_take ? CNT_W'(RDWR_C) : dec(rdgap_q);
    end
  end

  // ---------------------------------------------------------------
  // Status registers
  // ---------------------------------------------------------------
  logic       accept_q;
  logic [3:0] open_q;

  // Registered status outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accept_q <= 1'b0;
      open_q   <= 4'h0;
    end else begin
      accept_q <= take;
      open_q   <= bk_open | bk_in_ap;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign req_accept    = accept_q;
  assign bank_open     = open_q;
  assign wr_busy       = wr_busy_q;
  assign mem_ck        = ph_q;
  assign mem_ck_n      = ckn_q;
  assign mem_cke       = cke_q;
  assign mem_cs_n      = cmd_q[3];
  assign mem_ras_n     = cmd_q[2];
  assign mem_cas_n     = cmd_q[1];
  assign mem_we_n      = cmd_q[0];
  assign mem_addr      = addr_q;
  assign mem_ba        = ba_q;
  assign mem_dq_o      = dq_q;
  assign mem_dq_oe     = dq_oe_q;
  assign mem_strobe_o  = strb_q;
  assign mem_strobe_oe = strb_oe_q;
  assign mem_mask      = dm_q;
endmodule

// ===== tb/dwp_ctrl_props.sv
// Checker: command, strobe and timing properties at the controller ports
module dwp_ctrl_props
  import dwp_pkg::*;
#(
  parameter int DQ_W   = 16,
  parameter int ADDR_W = 13
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [1:0]        req_op,
  input wire logic [1:0]        req_bank,
  input wire logic              req_auto_pre,
  input wire logic              req_all,
  input wire logic              req_accept,
  input wire logic [3:0]        bank_open,
  input wire logic              wr_busy,
  input wire logic              mem_ck,
  input wire logic              mem_ck_n,
  input wire logic              mem_cke,
  input wire logic              mem_cs_n,
  input wire logic              mem_ras_n,
  input wire logic              mem_cas_n,
  input wire logic              mem_we_n,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [1:0]        mem_ba,
  input wire logic              mem_dq_oe,
  input wire logic [DQ_W/8-1:0] mem_strobe_o,
  input wire logic              mem_strobe_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // Command pins as one code
  wire logic [3:0] cmd;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};

  function automatic logic [3:0] op2cmd(input logic [1:0] op);
    return (op == 2'h0) ? CMD_ACT : (op == 2'h1) ? CMD_RD : (op == 2'h2) ? CMD_WR : CMD_PRE;
  endfunction

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cmd_map;
    req_accept |-> cmd == op2cmd($past(req_op)) && (mem_ba == $past(req_bank) || $past(req_all));
  endproperty
  a_cmd_map: assert property (p_cmd_map) else $error("command differs from request");
  property p_ap_bit;
    req_accept && $past(req_op) inside {2'h1, 2'h2} |-> mem_addr[AP_BIT] == $past(req_auto_pre);
  endproperty
  a_ap_bit: assert property (p_ap_bit) else $error("auto precharge bit wrong");
  property p_pre_all;
    req_accept && $past(req_op) == 2'h3 && $past(req_all) |-> mem_addr[AP_BIT] ##[0:1] bank_open == 4'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all not applied");
  property p_wr_strobe;
    req_accept && cmd == CMD_WR |-> ##1 mem_strobe_oe && mem_strobe_o == '0 ##2 mem_dq_oe && mem_strobe_o == '1;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("first strobe edge misplaced");
  property p_strobe_tog;
    mem_dq_oe && $past(mem_dq_oe) |-> mem_strobe_o == ~$past(mem_strobe_o);
  endproperty
  a_strobe_tog: assert property (p_strobe_tog) else $error("strobe stopped toggling");
  property p_burst;
    $rose(mem_dq_oe) |-> mem_dq_oe [*4] ##1 !mem_dq_oe ##1 !mem_strobe_oe;
  endproperty
  a_burst: assert property (p_burst) else $error("burst slot count wrong");
  property p_ck_run;
    wr_busy |=> mem_cke && mem_ck != $past(mem_ck);
  endproperty
  a_ck_run: assert property (p_ck_run) else $error("link clock stalled in write");
  property p_ck_pair;
    mem_ck_n == ~mem_ck;
  endproperty
  a_ck_pair: assert property (p_ck_pair) else $error("link clock pair not complementary");
  property p_wtr;
    $fell(mem_dq_oe) |-> (cmd != CMD_RD) [*3];
  endproperty
  a_wtr: assert property (p_wtr) else $error("read too soon after write");
  c_wr_ap: cover property (req_accept && cmd == CMD_WR && mem_addr[AP_BIT]);
  c_rd: cover property (req_accept && cmd == CMD_RD);
  c_pre_all: cover property (req_accept && cmd == CMD_PRE && mem_addr[AP_BIT]);
endmodule

bind dwp_ctrl dwp_ctrl_props #(.DQ_W(DQ_W), .ADDR_W(ADDR_W)) u_props (
  .clk, .rst_n, .req_op, .req_bank, .req_auto_pre, .req_all, .req_accept, .bank_open, .wr_busy,
  .mem_ck, .mem_ck_n, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_addr, .mem_ba, .mem_dq_oe,
  .mem_strobe_o, .mem_strobe_oe
);

// ===== tb/dwp_dev_model.sv
// Partner model: device bank states and masked write-data capture
module dwp_dev_model
  import dwp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        mem_ck,
  input  wire logic        mem_cke,
  input  wire logic        mem_cs_n,
  input  wire logic        mem_ras_n,
  input  wire logic        mem_cas_n,
  input  wire logic        mem_we_n,
  input  wire logic [12:0] mem_addr,
  input  wire logic [1:0]  mem_ba,
  input  wire logic [15:0] mem_dq_o,
  input  wire logic        mem_dq_oe,
  input  wire logic [1:0]  mem_strobe_o,
  input  wire logic        mem_strobe_oe,
  input  wire logic [1:0]  mem_mask,
  output logic             cap_stb = 1'b0,
  output logic [15:0]      cap_data,
  output logic [7:0]       viol_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bank state 0 idle, 1 active, 2 precharging
  logic [1:0] st [4] = '{default: 2'h0};
  logic [2:0] cnt [4] = '{default: 3'h0};
  logic [7:0] v_cmd = 8'h00;
  logic [7:0] v_dat = 8'h00;
  logic [1:0] sq = 2'h0;
  assign viol_cnt = v_cmd + v_dat;

  // Commands sampled on the link clock rising edge
  always @(posedge mem_ck) begin
    if (mem_cke) begin
      for (int b = 0; b < 4; b++) begin
        if (st[b] == 2'h2 && cnt[b] <= 3'h1) st[b] = 2'h0;
        else if (st[b] == 2'h2) cnt[b] = cnt[b] - 3'h1;
      end
      case ({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n})
        CMD_ACT: begin
          if (st[mem_ba] != 2'h0) v_cmd++;
          st[mem_ba] = 2'h1;
        end
        CMD_RD, CMD_WR: begin
          if (st[mem_ba] != 2'h1) v_cmd++;
          if (mem_addr[AP_BIT]) cnt[mem_ba] = 3'h3;
          if (mem_addr[AP_BIT]) st[mem_ba] = 2'h2;
        end
        CMD_PRE: begin
          for (int b = 0; b < 4; b++) begin
            if ((mem_addr[AP_BIT] || 2'(b) == mem_ba) && st[b] == 2'h1) begin
              st[b] = 2'h2;
              cnt[b] = 3'h1;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Data taken mid-element, as a PHY quarter-cycle shift would do
  always @(negedge clk) begin
    cap_stb <= 1'b0;
    if (mem_dq_oe) begin
      if (mem_strobe_o !== ~sq || !mem_strobe_oe) v_dat++;
      sq = mem_strobe_o;
      cap_data <= {mem_mask[1] ? 8'h00 : mem_dq_o[15:8], mem_mask[0] ? 8'h00 : mem_dq_o[7:0]};
      cap_stb <= 1'b1;
    end else begin
      sq = 2'h0;
    end
  end
endmodule

// ===== tb/dram_write_precharge_control_tb.sv
// Testbench: drives requests into the controller, checks commands and write data
module dram_write_precharge_control_tb
  import dwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_auto_pre = 1'b0, req_all = 1'b0;
  logic [1:0]  req_op = 2'h0, req_bank = 2'h0;
  logic [12:0] req_row = 13'h0000, req_col = 13'h0000, a = 13'h0000;
  logic [63:0] req_wdata = 64'h0;
  logic [7:0]  req_wmask = 8'h00;
  logic [4:0]  req_pairs = 5'h02;
  logic        req_accept, wr_busy, mem_ck, mem_ck_n, mem_cke, mem_dq_oe, mem_strobe_oe, cap_stb;
  logic        mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
  logic [3:0]  bank_open;
  logic [12:0] mem_addr;
  logic [1:0]  mem_ba, mem_strobe_o, mem_mask;
  logic [15:0] mem_dq_o, cap_data;
  logic [7:0]  viol_cnt;
  logic [18:0] e, w;
  logic [18:0] cq [$];
  logic [15:0] dq [$];
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  integer      seed = 32'hdcea;

  dwp_ctrl dut (.clk, .rst_n, .req_valid, .req_op, .req_bank, .req_row, .req_col, .req_auto_pre, .req_all,
    .req_wdata, .req_wmask, .req_pairs, .req_accept, .bank_open, .wr_busy, .mem_ck, .mem_ck_n, .mem_cke,
    .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_addr, .mem_ba, .mem_dq_o, .mem_dq_oe, .mem_strobe_o,
    .mem_strobe_oe, .mem_mask);
  dwp_dev_model u_dev (.clk, .mem_ck, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_addr,
    .mem_ba, .mem_dq_o, .mem_dq_oe, .mem_strobe_o, .mem_strobe_oe, .mem_mask, .cap_stb, .cap_data, .viol_cnt);

  always #5 clk = ~clk;

  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic rnd();
    a = 13'($random(seed));
    req_wdata = {$random(seed), $random(seed)};
    req_wmask = 8'($random(seed));
    req_pairs = 5'(($random(seed) & 3) % 3);
  endtask

  // Notes the expected command and data, then holds the request until taken or 60 clocks pass
  task automatic issue(input logic [1:0] op, input logic [1:0] bk, input logic ap, input logic all,
                       input logic take);
    int k;
    logic [1:0] m;
    k = 0;
    case (op)
      2'h0: cq.push_back({CMD_ACT, bk, a});
      2'h1: cq.push_back({CMD_RD, bk, a[12:11], ap, a[9:0]});
      2'h2: cq.push_back({CMD_WR, bk, a[12:11], ap, a[9:0]});
      default: cq.push_back({CMD_PRE, bk, 2'h0, all, 10'h000});
    endcase
    for (int i = 0; i < 4 && op == 2'h2; i++) begin
      m = req_wmask[2*i +: 2] | ((i >= 2 * req_pairs) ? 2'h3 : 2'h0);
      dq.push_back({m[1] ? 8'h00 : req_wdata[16*i+8 +: 8], m[0] ? 8'h00 : req_wdata[16*i +: 8]});
    end
    {req_valid, req_op, req_bank, req_row, req_col, req_auto_pre, req_all} = {1'b1, op, bk, a, a, ap, all};
    do begin
      @(negedge clk);
      k++;
    end while (req_accept !== 1'b1 && k < 60);
    chk({18'h0, req_accept === 1'b1}, {18'h0, take});
    if (req_accept !== 1'b1) void'(cq.pop_back());
    req_valid = 1'b0;
    @(negedge clk);
  endtask

  // Command monitor: oldest noted command against the pins
  always @(negedge clk) begin
    if (req_accept === 1'b1) begin
      e = cq.pop_front();
      w = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr};
      if (e[18:15] == CMD_PRE) w[12:0] = w[12:0] & 13'h0400;
      if (e[18:15] == CMD_PRE && e[10]) w[14:13] = e[14:13];
      chk(w, e);
    end
  end

  // Data monitor: each captured element against the oldest note
  always @(posedge clk) begin
    if (cap_stb === 1'b1) chk({3'h0, cap_data}, {3'h0, dq.pop_front()});
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    issue(2'h1, 2'h0, 1'b0, 1'b0, 1'b0);
    $display("test refuse done");
    for (int b = 0; b < 4; b++) begin
      rnd();
      issue(2'h0, 2'(b), 1'b0, 1'b0, 1'b1);
      issue(2'h2, 2'(b), b[0], 1'b0, 1'b1);
      issue(2'h1, 2'(b), 1'b0, 1'b0, !b[0]);
      issue(2'h3, 2'(b), 1'b0, 1'b0, 1'b1);
      $display("test bank %0d done", b);
    end
    for (int b = 0; b < 2; b++) issue(2'h0, 2'(b), 1'b0, 1'b0, 1'b1);
    for (int b = 0; b < 2; b++) begin
      rnd();
      issue(2'h2, 2'(b), 1'b0, 1'b0, 1'b1);
    end
    issue(2'h3, 2'h2, 1'b0, 1'b1, 1'b1);
    issue(2'h0, 2'h1, 1'b0, 1'b0, 1'b1);
    $display("test precharge all done");
    repeat (20) @(negedge clk);
    chk({11'h0, viol_cnt}, 19'h0);
    test_done();
  end
endmodule
